// ### pmusc_sequencer_control.sv
// Power management sequencer control: register file, update handshake and state sequencer.
//
// Notes on behaviour
// RQ1: under-voltage freeze bit is set-only, locks select.
// RQ2: over-voltage freeze bit is set-only, locks select.
// RQ3: under-voltage: 0 gives hard reset, 1 nothing.
// RQ4: over-voltage: 0 gives hard reset, 1 nothing.
// RQ5: update bit starts transfer, self-clears when done.
// RQ6: software leaves control alone while update busy.
// RQ7: trim, dwell, debug apply only on update.
// RQ8: charge-pump override needs debug enable set.
// RQ9: skip bit bypasses quiescent acknowledge wait.
// RQ10: hibernate request is write-only, reads zero.
// RQ11: software prepares wake hold before hibernate.
// RQ12: fast boot bit selects fast clock on power-up.
// RQ13: read-only flag shows bandgap good.
// RQ14: startup bias wait is fixed twelve ticks.
// RQ15: four dwell fields, reset four, set residence.
// RQ16: core regulator low power in deep sleep.
// RQ17: bandgap low quiescent in deep sleep.
// RQ18: keep core domain on in hibernate if set.
// RQ19: current limit codes go to analog, reset 8/4.
// RQ20: freeze bits clear only on hard reset.
// RQ21: dwell states count ticks to programmed value.
`timescale 1ns/1ps
module pmusc_sequencer_control #(
    parameter int LF_DIV_CYCLES = pmusc_pkg::LF_DIV
) (
    input  wire logic        i_core_clk,        // Core clock, 25 MHz.
    input  wire logic        i_rst,             // Asynchronous reset, active high.
    input  wire logic [31:0] i_addr,            // Register byte address.
    input  wire logic [31:0] i_wdata,           // Write data.
    input  wire logic        i_wr,              // Write strobe.
    input  wire logic        i_rd,              // Read strobe.
    output logic      [31:0] o_rdata,           // Read data, cycle after read strobe.
    input  wire logic        i_undervolt,       // Under-voltage detected.
    input  wire logic        i_overvolt,        // Over-voltage detected.
    input  wire logic        i_bandgap_good,    // Bandgap reported good.
    input  wire logic        i_quiescent_ack,   // Quiescent state acknowledge.
    input  wire logic        i_wake,            // Wake request out of hibernate.
    output logic             o_hard_reset,      // Hard reset request, high while a fault with select zero lasts.
    output logic             o_fast_clock_boot, // Use fast clock on power-up.
    output logic             o_cp_shutdown,     // Charge pump shutdown.
    output logic [4:0]       o_dbg_ctrl,        // Applied debug overrides.
    output logic [1:0]       o_dbg_discharge,   // Applied discharge test bits.
    output logic [2:0]       o_dbg_low_power,   // Applied debug low-power bits.
    output logic [31:0]      o_trim,            // Applied regulator trim word.
    output logic [3:0]       o_io_current_limit,   // Applied io regulator limit.
    output logic [3:0]       o_core_current_limit, // Applied core regulator limit.
    output logic             o_core_lp,         // Core regulator low-power now.
    output logic             o_bandgap_lp,      // Bandgap low-power now.
    output logic             o_core_domain_on,  // Core 1.5V domain enabled.
    output logic             o_core_attached,   // Core supply attached to MCU.
    output logic             o_io_attached,     // Io supply attached to MCU.
    output logic             o_hibernating,     // Chip in hibernate.
    output logic [3:0]       o_state            // Sequencer state.
);
    logic [31:0] ctl_q;
    logic [31:0] trim_q;
    logic [31:0] dwell_q;
    logic [31:0] trim_app_q;
    logic [31:0] dwell_app_q;
    logic [31:0] ctl_app_q;
    logic        uv_freeze_q;
    logic        ov_freeze_q;
    logic        uv_sel_q;
    logic        ov_sel_q;
    logic        busy_q;
    logic [2:0]  xfer_cnt_q;
    logic        hib_req_q;
    logic [15:0] div_q;
    logic        tick_q;
    logic [3:0]  dwell_cnt_q;
    logic        deep_sleep;
    pmusc_pkg::pmusc_state_t state_q;
    pmusc_pkg::pmusc_state_t state_d;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        hit = (a == b);
    endfunction

    function automatic logic [3:0] dwell_of(input logic [31:0] d, input int lo);
        dwell_of = d[lo +: 4];
    endfunction

    // Register writes; the control register is blocked while an update runs.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctl_q   <= pmusc_pkg::CTL_RESET;
            trim_q  <= pmusc_pkg::TRIM_RESET; // RQ19
            dwell_q <= pmusc_pkg::DWELL_RESET; // RQ15
        end
        else if (i_wr)
        begin
            if (hit(i_addr, pmusc_pkg::PMU_CONTROL_ADDR) && !busy_q) // RQ6
                ctl_q <= i_wdata & pmusc_pkg::CTL_WMASK;
            if (hit(i_addr, pmusc_pkg::REGULATOR_TRIM_ADDR))
                trim_q <= i_wdata & pmusc_pkg::TRIM_WMASK;
            if (hit(i_addr, pmusc_pkg::STATE_DWELL_ADDR))
                dwell_q <= i_wdata & pmusc_pkg::DWELL_WMASK;
        end
    end

    // Fault action select and set-only freezes; freezes leave only on hard reset.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            uv_freeze_q <= 1'b0; // RQ20
            ov_freeze_q <= 1'b0; // RQ20
            uv_sel_q    <= pmusc_pkg::FA_SELECT_RESET;
            ov_sel_q    <= pmusc_pkg::FA_SELECT_RESET;
        end
        else if (i_wr && hit(i_addr, pmusc_pkg::FAULT_ACTION_ADDR))
        begin
            if (!uv_freeze_q) // RQ1
                uv_sel_q <= i_wdata[pmusc_pkg::FA_UV_SELECT];
            if (!ov_freeze_q) // RQ2
                ov_sel_q <= i_wdata[pmusc_pkg::FA_OV_SELECT];
            uv_freeze_q <= uv_freeze_q | i_wdata[pmusc_pkg::FA_UV_FREEZE]; // RQ1
            ov_freeze_q <= ov_freeze_q | i_wdata[pmusc_pkg::FA_OV_FREEZE]; // RQ2
        end
    end

    // Hard reset request on a voltage fault whose select is zero.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_hard_reset <= 1'b0;
        else
            o_hard_reset <= (i_undervolt && !uv_sel_q)  // RQ3
                         || (i_overvolt && !ov_sel_q);  // RQ4
    end

    // Update handshake: staged values move to the applied copies over a fixed transfer.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_q      <= 1'b0;
            xfer_cnt_q  <= 3'd0;
            trim_app_q  <= pmusc_pkg::TRIM_RESET;
            dwell_app_q <= pmusc_pkg::DWELL_RESET;
            ctl_app_q   <= pmusc_pkg::CTL_RESET;
        end
        else if (!busy_q)
        begin
            if (i_wr && hit(i_addr, pmusc_pkg::PMU_CONTROL_ADDR)
                && i_wdata[pmusc_pkg::CTL_UPDATE])
            begin
                busy_q     <= 1'b1; // RQ5
                xfer_cnt_q <= 3'(pmusc_pkg::XFER_CYCLES - 1);
            end
        end
        else if (xfer_cnt_q == 3'd0)
        begin
            busy_q      <= 1'b0; // RQ5
            trim_app_q  <= trim_q; // RQ7
            dwell_app_q <= dwell_q; // RQ7
            ctl_app_q   <= ctl_q; // RQ7
        end
        else
            xfer_cnt_q <= xfer_cnt_q - 3'd1;
    end

    // Hibernate request is captured as an event, never stored as a readable bit.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            hib_req_q <= 1'b0;
        else if (i_wr && hit(i_addr, pmusc_pkg::PMU_CONTROL_ADDR) && !busy_q
                 && i_wdata[pmusc_pkg::CTL_HIBERNATE])
            hib_req_q <= 1'b1; // RQ10
        else if (state_q == pmusc_pkg::PMUSC_ACTIVE)
            hib_req_q <= 1'b0;
    end

    // Low-frequency tick divider.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (div_q == 16'(LF_DIV_CYCLES - 1))
        begin
            div_q  <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Sequencer next state.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pmusc_pkg::PMUSC_ACTIVE:
                if (hib_req_q)
                    state_d = pmusc_pkg::PMUSC_WAIT_QUIESCENT_ACKNOWLEDGE;
            pmusc_pkg::PMUSC_WAIT_QUIESCENT_ACKNOWLEDGE:
                if (ctl_q[pmusc_pkg::CTL_SKIP_QUIESCENT_ACKNOWLEDGE] || i_quiescent_ack) // RQ9
                    state_d = pmusc_pkg::PMUSC_PDOWN;
            pmusc_pkg::PMUSC_PDOWN:
                if (tick_q && dwell_cnt_q >= dwell_of(dwell_app_q, pmusc_pkg::DW_PDOWN_LO))
                    state_d = pmusc_pkg::PMUSC_HIBERNATE; // RQ21
            pmusc_pkg::PMUSC_HIBERNATE:
                if (i_wake)
                    state_d = pmusc_pkg::PMUSC_STARTUP_BIAS;
            pmusc_pkg::PMUSC_STARTUP_BIAS:
                if (tick_q && dwell_cnt_q >= pmusc_pkg::STARTUP_BIAS_TICKS) // RQ14
                    state_d = pmusc_pkg::PMUSC_SETTLE;
            pmusc_pkg::PMUSC_SETTLE:
                if (tick_q && dwell_cnt_q >= dwell_of(dwell_app_q, pmusc_pkg::DW_SETTLE_LO))
                    state_d = pmusc_pkg::PMUSC_CORE_ATTACH; // RQ15
            pmusc_pkg::PMUSC_CORE_ATTACH:
                if (tick_q && dwell_cnt_q >= dwell_of(dwell_app_q, pmusc_pkg::DW_CORE_LO))
                    state_d = pmusc_pkg::PMUSC_IO_ATTACH; // RQ15
            pmusc_pkg::PMUSC_IO_ATTACH:
                if (tick_q && dwell_cnt_q >= dwell_of(dwell_app_q, pmusc_pkg::DW_IO_LO))
                    state_d = pmusc_pkg::PMUSC_ACTIVE; // RQ15
            default:
                state_d = pmusc_pkg::PMUSC_ACTIVE;
        endcase
    end

    // State register and dwell tick counter, restarted on every state change.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q     <= pmusc_pkg::PMUSC_ACTIVE;
            dwell_cnt_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                dwell_cnt_q <= 4'h0;
            else if (tick_q && dwell_cnt_q != 4'hF)
                dwell_cnt_q <= dwell_cnt_q + 4'h1; // RQ21
        end
    end

    assign deep_sleep = (state_q == pmusc_pkg::PMUSC_HIBERNATE)
                        && ctl_app_q[pmusc_pkg::CTL_KEEP_SLEEP];

    // Outputs toward the analog part, all registered.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_fast_clock_boot    <= pmusc_pkg::CTL_RESET[pmusc_pkg::CTL_FAST_BOOT];
            o_cp_shutdown        <= 1'b0;
            o_dbg_ctrl           <= 5'h00;
            o_dbg_discharge      <= 2'h0;
            o_dbg_low_power      <= 3'h0;
            o_trim               <= pmusc_pkg::TRIM_RESET;
            o_io_current_limit   <= 4'h8;
            o_core_current_limit <= 4'h4;
            o_core_lp            <= 1'b0;
            o_bandgap_lp         <= 1'b0;
            o_core_domain_on     <= 1'b1;
            o_core_attached      <= 1'b1;
            o_io_attached        <= 1'b1;
            o_hibernating        <= 1'b0;
            o_state              <= 4'h0;
        end
        else
        begin
            o_fast_clock_boot <= ctl_q[pmusc_pkg::CTL_FAST_BOOT]; // RQ12
            o_cp_shutdown     <= ctl_app_q[pmusc_pkg::CTL_DBG_EN]
                                 && ctl_app_q[pmusc_pkg::CTL_CP_OVR]; // RQ8
            o_dbg_ctrl        <= ctl_app_q[pmusc_pkg::CTL_DBG_HI:pmusc_pkg::CTL_DBG_LO]; // RQ7
            o_dbg_discharge   <= ctl_app_q[pmusc_pkg::CTL_DISCH_HI:pmusc_pkg::CTL_DISCH_LO];
            o_dbg_low_power   <= ctl_app_q[pmusc_pkg::CTL_DLP_HI:pmusc_pkg::CTL_DLP_LO];
            o_trim            <= trim_app_q; // RQ7
            o_io_current_limit   <= trim_app_q[pmusc_pkg::TRIM_IO_OCP_LO +: 4]; // RQ19
            o_core_current_limit <= trim_app_q[pmusc_pkg::TRIM_CORE_OCP_LO +: 4]; // RQ19
            o_core_lp         <= deep_sleep && ctl_app_q[pmusc_pkg::CTL_LP_CORE]; // RQ16
            o_bandgap_lp      <= deep_sleep && ctl_app_q[pmusc_pkg::CTL_BG_LOWIQ]; // RQ17
            o_core_domain_on  <= (state_q != pmusc_pkg::PMUSC_HIBERNATE
                                  && state_q != pmusc_pkg::PMUSC_STARTUP_BIAS)
                                 || deep_sleep; // RQ18
            o_core_attached   <= state_q == pmusc_pkg::PMUSC_ACTIVE
                                 || state_q == pmusc_pkg::PMUSC_WAIT_QUIESCENT_ACKNOWLEDGE
                                 || state_q == pmusc_pkg::PMUSC_CORE_ATTACH
                                 || state_q == pmusc_pkg::PMUSC_IO_ATTACH;
            o_io_attached     <= state_q == pmusc_pkg::PMUSC_ACTIVE
                                 || state_q == pmusc_pkg::PMUSC_WAIT_QUIESCENT_ACKNOWLEDGE
                                 || state_q == pmusc_pkg::PMUSC_IO_ATTACH;
            o_hibernating     <= state_q == pmusc_pkg::PMUSC_HIBERNATE;
            o_state           <= 4'(state_q);
        end
    end

    // Read data; the hibernate bit always reads zero and unmapped addresses read zero.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 32'h0000_0000;
        else if (!i_rd)
            o_rdata <= 32'h0000_0000;
        else if (hit(i_addr, pmusc_pkg::PMU_CONTROL_ADDR))
        begin
            o_rdata <= ctl_q; // RQ10
            o_rdata[pmusc_pkg::CTL_UPDATE]  <= busy_q; // RQ5
            o_rdata[pmusc_pkg::CTL_BG_GOOD] <= i_bandgap_good; // RQ13
        end
        else if (hit(i_addr, pmusc_pkg::REGULATOR_TRIM_ADDR))
            o_rdata <= trim_q;
        else if (hit(i_addr, pmusc_pkg::STATE_DWELL_ADDR))
            o_rdata <= dwell_q;
        else if (hit(i_addr, pmusc_pkg::FAULT_ACTION_ADDR))
        begin
            o_rdata <= 32'h0000_0000;
            o_rdata[pmusc_pkg::FA_UV_FREEZE] <= uv_freeze_q;
            o_rdata[pmusc_pkg::FA_OV_FREEZE] <= ov_freeze_q;
            o_rdata[pmusc_pkg::FA_UV_SELECT] <= uv_sel_q;
            o_rdata[pmusc_pkg::FA_OV_SELECT] <= ov_sel_q;
        end
        else
            o_rdata <= 32'h0000_0000;
    end
endmodule

// ### pmusc_pkg.sv
// Package of register offsets, field positions, reset values and timing counts.
package pmusc_pkg;
    localparam logic [31:0] PMU_CONTROL_ADDR      = 32'h5000_0040;
    localparam logic [31:0] REGULATOR_TRIM_ADDR   = 32'h5000_0044;
    localparam logic [31:0] STATE_DWELL_ADDR      = 32'h5000_0048;
    localparam logic [31:0] BAT_MON_CTRL_ADDR     = 32'h5000_004C;
    localparam logic [31:0] BAT_MON_TRIM_ADDR     = 32'h5000_0050;
    localparam logic [31:0] BAT_DBNC_SEL_ADDR     = 32'h5000_0054;
    localparam logic [31:0] BAT_DBNC_THR_ADDR     = 32'h5000_0058;
    localparam logic [31:0] VMON_IRQ_ADDR         = 32'h5000_005C;
    localparam logic [31:0] FAULT_ACTION_ADDR     = 32'h5000_002C;

    // Control register fields.
    localparam int CTL_UPDATE       = 31;
    localparam int CTL_DBG_HI       = 29;
    localparam int CTL_DBG_LO       = 25;
    localparam int CTL_CP_OVR       = 24;
    localparam int CTL_KEEP_SLEEP   = 21;
    localparam int CTL_DISCH_HI     = 20;
    localparam int CTL_DISCH_LO     = 19;
    localparam int CTL_DBG_EN       = 17;
    localparam int CTL_SKIP_QUIESCENT_ACKNOWLEDGE    = 16;
    localparam int CTL_LP_CORE      = 13;
    localparam int CTL_BG_LOWIQ     = 12;
    localparam int CTL_LDO_CHOOSE   = 11;
    localparam int CTL_DLP_HI       = 10;
    localparam int CTL_DLP_LO       = 8;
    localparam int CTL_BG_GOOD      = 4;
    localparam int CTL_FAST_BOOT    = 1;
    localparam int CTL_HIBERNATE    = 0;
    localparam logic [31:0] CTL_RESET = 32'h0000_3002;
    localparam logic [31:0] CTL_WMASK = 32'h3F3B_3F02;

    // Fault action register fields.
    localparam int FA_UV_FREEZE     = 31;
    localparam int FA_OV_FREEZE     = 27;
    localparam int FA_UV_SELECT     = 4;
    localparam int FA_OV_SELECT     = 0;
    localparam logic FA_SELECT_RESET = 1'b1;

    // Trim register layout and reset value.
    localparam logic [31:0] TRIM_WMASK = 32'h733F_1FFF;
    localparam logic [31:0] TRIM_RESET = 32'h0000_0084;
    localparam int TRIM_IO_OCP_LO   = 4;
    localparam int TRIM_CORE_OCP_LO = 0;

    // Dwell register layout and reset value.
    localparam logic [31:0] DWELL_WMASK = 32'h0000_FFFF;
    localparam logic [31:0] DWELL_RESET = 32'h0000_4444;
    localparam int DW_SETTLE_LO  = 0;
    localparam int DW_CORE_LO    = 4;
    localparam int DW_IO_LO      = 8;
    localparam int DW_PDOWN_LO   = 12;
    localparam int DW_W          = 4;

    // Low-frequency tick: 16 kHz from the 25 MHz core clock.
    localparam int CORE_CLK_HZ   = 25_000_000;
    localparam int LF_CLK_HZ     = 16_000;
    localparam int LF_DIV        = CORE_CLK_HZ / LF_CLK_HZ;
    localparam logic [3:0] STARTUP_BIAS_TICKS = 4'hC;
    // Cycles the staged-to-applied transfer takes.
    localparam int XFER_CYCLES   = 4;

    typedef enum logic [3:0] {
        PMUSC_ACTIVE,
        PMUSC_WAIT_QUIESCENT_ACKNOWLEDGE,
        PMUSC_PDOWN,
        PMUSC_HIBERNATE,
        PMUSC_STARTUP_BIAS,
        PMUSC_SETTLE,
        PMUSC_CORE_ATTACH,
        PMUSC_IO_ATTACH
    } pmusc_state_t;
endpackage

// ### pmusc_properties.sv
// Port-level assertions for the sequencer control block.
`timescale 1ns/1ps
module pmusc_properties #(
    parameter int LF_DIV_CYCLES = 4
) (
    input wire logic        i_core_clk,       // Core clock.
    input wire logic        i_rst,            // Reset.
    input wire logic [31:0] i_addr,           // Address.
    input wire logic        i_rd,             // Read strobe.
    input wire logic [31:0] o_rdata,          // Read data.
    input wire logic        i_undervolt,      // Under-voltage.
    input wire logic        i_overvolt,       // Over-voltage.
    input wire logic        i_bandgap_good,   // Bandgap good.
    input wire logic        i_wake,           // Wake.
    input wire logic        o_hard_reset,     // Hard reset.
    input wire logic        o_core_lp,        // Core low power.
    input wire logic        o_bandgap_lp,     // Bandgap low power.
    input wire logic        o_core_domain_on, // Core domain on.
    input wire logic        o_hibernating,    // Hibernating.
    input wire logic [3:0]  o_state           // State.
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    int bias_n;

    // Cycles spent so far in the startup bias wait.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            bias_n <= 0;
        else
            bias_n <= (o_state == 4'h4) ? bias_n + 1 : 0;
    end

    sequence s_ctl_read;
        i_rd && i_addr == pmusc_pkg::PMU_CONTROL_ADDR;
    endsequence
    sequence s_left_bias;
        $past(o_state) == 4'h4 && o_state != 4'h4;
    endsequence

    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("Read data not zero outside a read.");
    a_hib_reads_zero: assert property (s_ctl_read |=> !o_rdata[0])
        else $error("Hibernate request bit read back high.");
    a_bg_flag_read: assert property (s_ctl_read |=> o_rdata[4] == $past(i_bandgap_good))
        else $error("Bandgap flag does not follow its input.");
    a_hard_rst_cause: assert property (o_hard_reset
        |-> $past(i_undervolt || i_overvolt))
        else $error("Hard reset without a supply fault.");
    a_core_lp_hib: assert property (o_core_lp |-> o_hibernating && o_core_domain_on)
        else $error("Core low power outside deep sleep.");
    a_bg_lp_hib: assert property (o_bandgap_lp |-> o_hibernating && o_core_domain_on)
        else $error("Bandgap low power outside deep sleep.");
    a_state_order: assert property (o_state != $past(o_state)
        |-> o_state == (($past(o_state) + 4'h1) & 4'h7))
        else $error("Sequencer skipped or reversed a state.");
    a_wake_exit: assert property ($past(o_state) == 4'h3 && o_state == 4'h4
        |-> $past(i_wake))
        else $error("Hibernate left without wake.");
    a_bias_dwell: assert property (s_left_bias
        |-> bias_n > 12 * LF_DIV_CYCLES && bias_n <= 13 * LF_DIV_CYCLES)
        else $error("Startup bias wait has the wrong length.");
endmodule

bind pmusc_sequencer_control pmusc_properties #(.LF_DIV_CYCLES(LF_DIV_CYCLES)) u_chk (
    .i_core_clk, .i_rst, .i_addr, .i_rd, .o_rdata, .i_undervolt, .i_overvolt,
    .i_bandgap_good, .i_wake, .o_hard_reset, .o_core_lp, .o_bandgap_lp,
    .o_core_domain_on, .o_hibernating, .o_state
);

// ### test_pmusc_sequencer_control.sv
// Self-checking bench of the sequencer control block.
`timescale 1ns/1ps
module test_pmusc_sequencer_control;
    localparam int          D   = 4;
    localparam logic [31:0] CTL = pmusc_pkg::PMU_CONTROL_ADDR;
    localparam logic [31:0] TRM = pmusc_pkg::REGULATOR_TRIM_ADDR;
    localparam logic [31:0] DWL = pmusc_pkg::STATE_DWELL_ADDR;
    localparam logic [31:0] FA  = pmusc_pkg::FAULT_ACTION_ADDR;
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [31:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_undervolt = 1'b0;
    logic        i_overvolt = 1'b0;
    logic        i_bandgap_good = 1'b0;
    logic        i_quiescent_ack = 1'b0;
    logic        i_wake = 1'b0;
    logic [31:0] o_rdata, o_trim;
    logic        o_hard_reset, o_fast_clock_boot, o_cp_shutdown, o_core_lp, o_bandgap_lp;
    logic        o_core_domain_on, o_core_attached, o_io_attached, o_hibernating;
    logic [4:0]  o_dbg_ctrl;
    logic [1:0]  o_dbg_discharge;
    logic [2:0]  o_dbg_low_power;
    logic [3:0]  o_io_current_limit, o_core_current_limit, o_state;
    logic        bg;
    int          num_errors = 0;
    int          n_tests = 0;

    pmusc_sequencer_control #(.LF_DIV_CYCLES(D)) dut_u (.*);

    always #20 i_core_clk = ~i_core_clk;

    function automatic logic [31:0] ctl_exp(input logic [31:0] w);
        return (w & pmusc_pkg::CTL_WMASK) | ({31'h0, bg} << 4);
    endfunction

    task automatic test_done;
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask

    task automatic fail_wait(input string nm);
        num_errors++;
        $display("FAIL %s wait ran out", nm);
        test_done();
    endtask

    // Update with a second control write that lands while busy.
    task automatic upd(input logic [31:0] w);
        logic [31:0] d;
        int          k;
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= CTL;
        i_wdata <= w | 32'h8000_0000;
        @(posedge i_core_clk);
        i_wdata <= ~w & 32'h7FFF_FFFE;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        rd(CTL, d);
        chk("update busy", d[31], 1'b1);
        for (k = 0; d[31] === 1'b1; k++)
        begin
            if (k > 20)
                fail_wait("update");
            rd(CTL, d);
        end
        chk("control kept", d, ctl_exp(w));
        step(2);
    endtask

    task automatic flt(input int k, input logic e);
        @(posedge i_core_clk);
        i_undervolt <= (k == 0);
        i_overvolt <= (k == 1);
        @(posedge i_core_clk);
        #1 chk("hard reset", o_hard_reset, e);
        @(posedge i_core_clk);
        i_undervolt <= 1'b0;
        i_overvolt <= 1'b0;
    endtask

    task automatic wait_st(input logic [3:0] s, output int n);
        for (n = 0; o_state !== s; n++)
        begin
            if (n > 3000)
                fail_wait("state");
            step(1);
        end
    endtask

    initial
    begin
        logic [31:0] w, t, tq, dw, d;
        int          n, f;
        void'($urandom(91642));
        bg = 1'($urandom);
        i_bandgap_good <= bg;
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rchk("ctl reset", CTL, ctl_exp(pmusc_pkg::CTL_RESET));
        rchk("trim reset", TRM, pmusc_pkg::TRIM_RESET);
        rchk("dwell reset", DWL, pmusc_pkg::DWELL_RESET);
        rchk("fault reset", FA, 32'h0000_0011);
        rchk("unmapped", 32'h5000_0060, '0);
        chk("io limit", o_io_current_limit, 4'h8);
        chk("core limit", o_core_current_limit, 4'h4);
        chk("fast boot", o_fast_clock_boot, 1'b1);
        flt(0, 1'b0);
        flt(1, 1'b0);
        tq = pmusc_pkg::TRIM_RESET;
        for (int i = 0; i < 4; i++)
        begin
            w = $urandom & 32'h7FFF_FFFE;
            w[17] = i[0];
            w[24] = i[1];
            t = $urandom;
            wr(TRM, t);
            step(1);
            chk("trim held", o_trim, tq);
            rchk("trim read", TRM, t & pmusc_pkg::TRIM_WMASK);
            upd(w);
            tq = t & pmusc_pkg::TRIM_WMASK;
            chk("trim applied", o_trim, tq);
            chk("io limit", o_io_current_limit, tq[7:4]);
            chk("core limit", o_core_current_limit, tq[3:0]);
            chk("debug", o_dbg_ctrl, w[29:25]);
            chk("discharge", o_dbg_discharge, w[20:19]);
            chk("debug low power", o_dbg_low_power, w[10:8]);
            chk("charge pump", o_cp_shutdown, w[17] & w[24]);
            chk("fast boot", o_fast_clock_boot, w[1]);
        end
        for (int k = 0; k < 2; k++)
        begin
            f = k ? pmusc_pkg::FA_OV_SELECT : pmusc_pkg::FA_UV_SELECT;
            n = k ? pmusc_pkg::FA_OV_FREEZE : pmusc_pkg::FA_UV_FREEZE;
            wr(FA, '0);
            flt(k, 1'b1);
            wr(FA, 32'h1 << n);
            wr(FA, 32'h0000_0011);
            rd(FA, d);
            chk("freeze", d[n], 1'b1);
            chk("select held", d[f], 1'b0);
            flt(k, 1'b1);
        end
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rchk("freeze reset", FA, 32'h0000_0011);
        for (int r = 0; r < 2; r++)
        begin
            dw = ($urandom & 32'h0000_0333) | 32'h0000_3000;
            wr(DWL, dw);
            w = ($urandom & 32'h0000_3000) | (r << 16) | (r << 21);
            upd(w);
            wr(CTL, w | 32'h0000_0001);
            rchk("hibernate bit", CTL, ctl_exp(w));
            if (r == 0)
            begin
                step(20);
                chk("quiescent_acknowledge wait", o_state, 4'h1);
                @(posedge i_core_clk) i_quiescent_ack <= 1'b1;
            end
            wait_st(4'h2, n);
            wait_st(4'h3, n);
            chk("pdown dwell", n > 3 * D && n <= 4 * D, 1'b1);
            @(posedge i_core_clk) i_quiescent_ack <= 1'b0;
            step(1);
            chk("hibernating", o_hibernating, 1'b1);
            chk("domain", o_core_domain_on, w[21]);
            chk("core lp", o_core_lp, w[21] & w[13]);
            chk("bandgap lp", o_bandgap_lp, w[21] & w[12]);
            @(posedge i_core_clk) i_wake <= 1'b1;
            wait_st(4'h4, n);
            @(posedge i_core_clk) i_wake <= 1'b0;
            wait_st(4'h5, n);
            for (int s = 0; s < 3; s++)
            begin
                wait_st(4'((6 + s) % 8), n);
                f = dw[4 * s +: 4];
                chk("dwell", n > f * D && n <= (f + 1) * D, 1'b1);
            end
            step(1);
            chk("active outputs", {o_core_attached, o_io_attached, o_core_domain_on,
                o_hibernating}, 4'b1110);
        end
        test_done();
    end
endmodule
